//--- core/ccp_pkg.sv
package ccp_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_PERIOD = 5'h04;
  localparam logic [4:0] ADDR_CMPA = 5'h08;
  localparam logic [4:0] ADDR_CMPB = 5'h0c;
  localparam logic [4:0] ADDR_TIMER = 5'h10;
  localparam logic [4:0] ADDR_CAPT = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hbfff; // Bit 14 reads as zero
  localparam logic [31:0] PERIOD_RESET = 32'hffffffff;
  // ----------------------------------------
  // Function codes
  // ----------------------------------------
  localparam logic [3:0] FS_BOTH = 4'h0;
  localparam logic [3:0] FS_RISE = 4'h1;
  localparam logic [3:0] FS_FALL = 4'h2;
  localparam logic [3:0] FS_RISEFALL = 4'h3;
  localparam logic [3:0] FS_RISE4 = 4'h4;
  localparam logic [3:0] FS_RISE16 = 4'h5;
  localparam logic [3:0] FS_TIMER = 4'h0;
  localparam logic [3:0] FS_SETHI = 4'h1;
  localparam logic [3:0] FS_SETLO = 4'h2;
  localparam logic [3:0] FS_TOGGLE = 4'h3;
  localparam logic [3:0] FS_DUAL = 4'h4;
  localparam logic [3:0] FS_DUALBUF = 4'h5;
  localparam logic [3:0] FS_EXTERN = 4'hf;
  localparam logic [2:0] SRC_SYSCLK = 3'h0;
  // Edge counts and prescaler limits (count minus one)
  localparam logic [3:0] EDGES_4_LAST = 4'h3;
  localparam logic [3:0] EDGES_16_LAST = 4'hf;
  localparam logic [5:0] DIV1_LAST = 6'h00;
  localparam logic [5:0] DIV4_LAST = 6'h03;
  localparam logic [5:0] DIV16_LAST = 6'h0f;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic unitEnable;
    logic unused14;
    logic stopInIdle;
    logic runInSleep;
    logic timebaseClockResync;
    logic [2:0] timebaseSourcePick;
    logic [1:0] timebaseDivider;
    logic wideTimer;
    logic captureCompareChoice;
    logic [3:0] functionSelect;
  } ctrl_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } unit_state_t;
endpackage

//--- core/timebase_tick.sv
`timescale 1ns/1ns
`default_nettype none
module timebase_tick (
  // Clock and reset
  input wire logic sysClk,
  input wire logic nrst,
  // Settings
  input wire logic run,
  input wire logic [2:0] sourcePick,
  input wire logic resync,
  input wire logic [1:0] divider,
  // Time-base sources, bit 0 unused (system clock)
  input wire logic [7:0] extClk,
  // Prescaled tick
  output logic tick
);
  // ----------------------------------------
  // Source selection and resync
  // ----------------------------------------
  function automatic logic [5:0] divLast(input logic [1:0] d);
    case (d)
      2'b00: divLast = ccp_pkg::DIV1_LAST;
      2'b01: divLast = ccp_pkg::DIV4_LAST;
      2'b10: divLast = ccp_pkg::DIV16_LAST;
      default: divLast = ccp_pkg::DIV64_LAST;
    endcase
  endfunction
  logic [7:0] syncA;
  logic [7:0] syncB;
  logic srcPrev;
  logic [5:0] divCnt;
  wire logic chosen;
  wire logic srcEdge;
  wire logic divWrap;
  // Resync path costs two cycles; only async sources need it
  assign chosen = resync ? syncB[sourcePick] : extClk[sourcePick];
  assign srcEdge = (sourcePick == ccp_pkg::SRC_SYSCLK) ? 1'b1 : (chosen & ~srcPrev);
  assign divWrap = (divCnt >= divLast(divider));
  // Synchroniser, edge history and prescaler
  always_ff @(posedge sysClk or negedge nrst) begin
    if (!nrst) begin
      syncA <= 8'h00;
      syncB <= 8'h00;
      srcPrev <= 1'b0;
      divCnt <= 6'h00;
      tick <= 1'b0;
    end else begin
      syncA <= extClk;
      syncB <= syncA;
      srcPrev <= chosen;
      if (!run) begin
        divCnt <= 6'h00;
      end else if (srcEdge) begin
        divCnt <= divWrap ? 6'h00 : divCnt + 6'h01;
      end
      tick <= run & srcEdge & divWrap;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SYSCLK_DIV1: assert property (@(posedge sysClk) disable iff (!nrst)
    (run && sourcePick == 3'h0 && divider == 2'b00) |=> tick)
    else $error("system clock at 1:1 did not tick every cycle");
  AST_DIV4_GAP: assert property (@(posedge sysClk) disable iff (!nrst)
    (tick && divider == 2'b01 && sourcePick == 3'h0 && run) |=> !tick [*3])
    else $error("divide by 4 ticked too early");
  AST_RESYNC_DELAY: assert property (@(posedge sysClk) disable iff (!nrst)
    (run && resync && sourcePick != 3'h0 && divider == 2'b00
      && $rose(extClk[sourcePick]) && $stable(sourcePick))
    |-> ##3 (tick || !run || $changed(sourcePick)))
    else $error("resynchronised edge did not tick after three cycles");
endmodule
`default_nettype wire

//--- core/capture_compare_unit.sv
`timescale 1ns/1ns
`default_nettype none
module capture_compare_unit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire ccp_pkg::bus_req_t busReq,
  output logic [31:0] rdata,
  // Device and signal inputs
  input wire logic sleepActive,
  input wire logic [7:0] extClk,
  input wire logic captureIn,
  // Unit outputs
  output logic compareOut,
  output logic captureEvent,
  output logic [31:0] captureValue,
  output logic running
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ccp_pkg::ctrl_t ctrl;
  ccp_pkg::unit_state_t state;
  logic [31:0] period;
  logic [31:0] cmpA;
  logic [31:0] cmpB;
  logic [31:0] cmpAAct;
  logic [31:0] cmpBAct;
  logic [31:0] timer;
  logic capPrev;
  logic [3:0] capCnt;
  logic captureFlag;
  wire logic tick;
  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire logic wrCtrl = busReq.wr && busReq.addr == ccp_pkg::ADDR_CTRL;
  wire logic wrPeriod = busReq.wr && busReq.addr == ccp_pkg::ADDR_PERIOD;
  wire logic wrCmpA = busReq.wr && busReq.addr == ccp_pkg::ADDR_CMPA;
  wire logic wrCmpB = busReq.wr && busReq.addr == ccp_pkg::ADDR_CMPB;
  wire logic rdCapt = busReq.rd && busReq.addr == ccp_pkg::ADDR_CAPT;
  wire logic [3:0] fs = ctrl.functionSelect;
  wire logic capMode = ctrl.captureCompareChoice;
  // Sleep halts the unit unless run-in-sleep is set
  wire logic next_run = ctrl.unitEnable && (!sleepActive || ctrl.runInSleep);
  wire ccp_pkg::unit_state_t next_state = !ctrl.unitEnable ? ccp_pkg::ST_OFF :
    (next_run ? ccp_pkg::ST_RUN : ccp_pkg::ST_HALT);
  wire logic [31:0] periodEff = ctrl.wideTimer ? period : {16'h0000, period[15:0]};
  wire logic periodHit = tick && (timer == periodEff);
  wire logic [31:0] next_timer = !next_run ? 32'h0000_0000 :
    (periodHit ? 32'h0000_0000 : (tick ? timer + 32'h0000_0001 : timer));
  // ----------------------------------------
  // Time base
  // ----------------------------------------
  timebase_tick u_tick (
    .sysClk(sys_clk),
    .nrst(nrst),
    .run(running),
    .sourcePick(ctrl.timebaseSourcePick),
    .resync(ctrl.timebaseClockResync),
    .divider(ctrl.timebaseDivider),
    .extClk(extClk),
    .tick(tick)
  );
  // ----------------------------------------
  // Capture decode
  // ----------------------------------------
  wire logic rise = captureIn & ~capPrev;
  wire logic fall = ~captureIn & capPrev;
  wire logic [3:0] capLast = (fs == ccp_pkg::FS_RISE16) ? ccp_pkg::EDGES_16_LAST
    : ccp_pkg::EDGES_4_LAST;
  wire logic prescaled = (fs == ccp_pkg::FS_RISE4 || fs == ccp_pkg::FS_RISE16);
  wire logic capHit =
    ((fs == ccp_pkg::FS_BOTH || fs == ccp_pkg::FS_RISEFALL) && (rise || fall)) ||
    (fs == ccp_pkg::FS_RISE && rise) ||
    (fs == ccp_pkg::FS_FALL && fall) ||
    (prescaled && rise && capCnt == capLast);
  // Reserved capture codes never match above, so they stay silent
  wire logic captureFire = running && capMode && capHit;
  // ----------------------------------------
  // Compare decode
  // ----------------------------------------
  wire logic cmpMode = running && !capMode;
  wire logic matchA = cmpMode && tick && timer == cmpAAct;
  wire logic matchB = cmpMode && tick && timer == cmpBAct;
  wire logic buffered = (fs == ccp_pkg::FS_DUALBUF);
  logic next_out;
  always_comb begin
    next_out = compareOut;
    if (!cmpMode) begin
      next_out = 1'b0;
    end else begin
      case (fs)
        ccp_pkg::FS_TIMER: next_out = 1'b0;
        ccp_pkg::FS_SETHI: next_out = matchA ? 1'b1 : compareOut;
        ccp_pkg::FS_SETLO: next_out = matchA ? 1'b0 : compareOut;
        ccp_pkg::FS_TOGGLE: next_out = matchA ? ~compareOut : compareOut;
        ccp_pkg::FS_DUAL, ccp_pkg::FS_DUALBUF: begin
          // Rising edge on the first compare, falling on the second
          if (matchA) begin
            next_out = 1'b1;
          end else if (matchB) begin
            next_out = 1'b0;
          end
        end
        ccp_pkg::FS_EXTERN: next_out = captureIn;
        default: next_out = 1'b0;
      endcase
    end
  end
  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic [31:0] next_rdata =
    !busReq.rd ? 32'h0000_0000 :
    (busReq.addr == ccp_pkg::ADDR_CTRL) ? {16'h0000, ctrl} :
    (busReq.addr == ccp_pkg::ADDR_PERIOD) ? period :
    (busReq.addr == ccp_pkg::ADDR_CMPA) ? cmpA :
    (busReq.addr == ccp_pkg::ADDR_CMPB) ? cmpB :
    (busReq.addr == ccp_pkg::ADDR_TIMER) ? timer :
    (busReq.addr == ccp_pkg::ADDR_CAPT) ? captureValue :
    (busReq.addr == ccp_pkg::ADDR_STATUS) ? {27'h0, state, compareOut, captureFlag} :
    32'h0000_0000;
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= ccp_pkg::CTRL_RESET;
      period <= ccp_pkg::PERIOD_RESET;
      cmpA <= 32'h0000_0000;
      cmpB <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
    end else begin
      if (wrCtrl) ctrl <= busReq.wdata[15:0] & ccp_pkg::CTRL_WMASK;
      if (wrPeriod) period <= busReq.wdata;
      if (wrCmpA) cmpA <= busReq.wdata;
      if (wrCmpB) cmpB <= busReq.wdata;
      rdata <= next_rdata;
    end
  end
  // Active compares: buffered mode loads them only at period rollover or while the unit is not running,
  // so a mid-period write cannot glitch the pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmpAAct <= 32'h0000_0000;
      cmpBAct <= 32'h0000_0000;
    end else if (!buffered || periodHit || !running) begin
      cmpAAct <= cmpA;
      cmpBAct <= cmpB;
    end
  end
  // ----------------------------------------
  // Unit state, timer, capture and output
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ccp_pkg::ST_OFF;
      running <= 1'b0;
      timer <= 32'h0000_0000;
      capPrev <= 1'b0;
      capCnt <= 4'h0;
      captureEvent <= 1'b0;
      captureValue <= 32'h0000_0000;
      captureFlag <= 1'b0;
      compareOut <= 1'b0;
    end else begin
      state <= next_state;
      running <= next_run;
      timer <= next_timer;
      capPrev <= captureIn;
      if (!(running && capMode && prescaled)) begin
        capCnt <= 4'h0;
      end else if (rise) begin
        capCnt <= (capCnt == capLast) ? 4'h0 : capCnt + 4'h1;
      end
      captureEvent <= captureFire;
      if (captureFire) captureValue <= timer;
      // A capture in the same cycle as the read keeps the flag set
      captureFlag <= captureFire | (captureFlag & ~rdCapt);
      compareOut <= next_out;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SLEEP_HALT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sleepActive && !ctrl.runInSleep) |=> !running && timer == 32'h0)
    else $error("unit kept running in sleep");
  AST_DISABLED_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    !ctrl.unitEnable |=> !running && timer == 32'h0 ##1 !compareOut)
    else $error("disabled unit not idle");
  AST_EDGE_CAPTURE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (running && capMode && fs == 4'h0 && (rise || fall))
    |=> captureEvent && captureValue == $past(timer))
    else $error("edge detect missed a capture");
  AST_RISE_IGNORES_FALL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (capMode && fs == 4'h1 && fall) |=> !captureEvent)
    else $error("rising-edge mode captured on a falling edge");
  AST_FALL_CAPTURE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (running && capMode && fs == 4'h2 && fall) |=> captureEvent)
    else $error("falling-edge mode missed an edge");
  AST_FOURTH_RISE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (captureEvent && $past(fs) == 4'h4) |-> $past(capCnt) == 4'h3 && $past(rise))
    else $error("every-fourth capture at wrong count");
  AST_SIXTEENTH_RISE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (captureEvent && $past(fs) == 4'h5) |-> $past(capCnt) == 4'hf)
    else $error("every-sixteenth capture at wrong count");
  AST_RESERVED_SILENT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (capMode && (fs[3] || fs[3:1] == 3'b011)) |=> !captureEvent)
    else $error("reserved capture code captured");
  AST_TIMER_NO_OUT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!capMode && fs == 4'h0) |=> !compareOut)
    else $error("timer mode drove the output");
  AST_SET_HIGH: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fs == 4'h1 && matchA) |=> compareOut)
    else $error("output not driven high on match");
  AST_SET_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fs == 4'h2 && matchA) |=> !compareOut)
    else $error("output not driven low on match");
  AST_TOGGLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fs == 4'h3 && matchA) |=> compareOut != $past(compareOut))
    else $error("output did not toggle on match");
  AST_DUAL_FALL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fs == 4'h4 && matchB && !matchA) |=> !compareOut)
    else $error("dual-edge output not cleared on second match");
  AST_EXTERNAL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmpMode && fs == 4'hf) |=> compareOut == $past(captureIn))
    else $error("external mode output does not follow input");
  COV_CAPTURE: cover property (@(posedge sys_clk) disable iff (!nrst)
    captureEvent && fs == 4'h4);
  COV_DUAL: cover property (@(posedge sys_clk) disable iff (!nrst)
    fs == 4'h5 && !capMode && $fell(compareOut));
  COV_SLEEP: cover property (@(posedge sys_clk) disable iff (!nrst)
    sleepActive && running);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic sys_clk;
  logic nrst;
  ccp_pkg::bus_req_t busReq;
  logic [31:0] rdata;
  logic sleepActive;
  logic [7:0] extClk;
  logic captureIn;
  logic compareOut;
  logic captureEvent;
  logic [31:0] captureValue;
  logic running;
  int n_mismatch = 0;
  int n_tests = 0;
  int nCapt = 0;
  int nCmp = 0;
  logic prevCmp = 1'b0;
  logic [31:0] q0;
  logic [31:0] q1;

  capture_compare_unit i_capture_compare_unit (
    .sys_clk(sys_clk), .nrst(nrst), .busReq(busReq), .rdata(rdata),
    .sleepActive(sleepActive), .extClk(extClk), .captureIn(captureIn),
    .compareOut(compareOut), .captureEvent(captureEvent),
    .captureValue(captureValue), .running(running)
  );

  // 100 ns clock
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // Event counters; registered outputs are sampled before the edge updates them.
  // They clear while reset is held, so each scenario counts from its own release.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      nCapt <= 0;
      nCmp <= 0;
      prevCmp <= 1'b0;
    end else begin
      if (captureEvent === 1'b1) nCapt <= nCapt + 1;
      if (compareOut !== prevCmp) nCmp <= nCmp + 1;
      prevCmp <= compareOut;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Write strobe stays up until the next access or idle, so accesses can abut
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
  endtask

  // Read data live only in the cycle after the strobe; taken at the edge closing it
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq <= '0;
    @(posedge sys_clk);
    q = rdata;
  endtask

  task automatic wait_cyc(input int n);
    busReq <= '0;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic do_reset;
    nrst <= 1'b0;
    busReq <= '0;
    captureIn <= 1'b0;
    sleepActive <= 1'b0;
    extClk <= 8'h00;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Row table: control word, captures, output changes (-1 skips)
  // ----------------------------------------
  typedef struct {
    logic [15:0] ctrl;
    int ec;
    int em;
  } row_t;
  // Output changes include the drop to low when the unit is switched off
  row_t rows [16] = '{
    '{16'h8010, 32, 0}, '{16'h8011, 16, 0}, '{16'h8012, 16, 0},
    '{16'h8013, 32, 0}, '{16'h8014, 4, 0}, '{16'h8015, 1, 0},
    '{16'h8016, 0, 0}, '{16'h8018, 0, 0}, '{16'h0013, 0, 0},
    '{16'h8000, 0, 0}, '{16'h8001, 0, 2}, '{16'h8003, 0, 4},
    '{16'h8004, 0, 8}, '{16'h8005, 0, 8}, '{16'h800f, 0, 32}, '{16'h8006, 0, 0}
  };

  // Sixteen rising and sixteen falling edges; compare period is 50 cycles
  task automatic run_row(input row_t r);
    do_reset;
    wr(ccp_pkg::ADDR_PERIOD, 32'd49);
    wr(ccp_pkg::ADDR_CMPA, 32'd3);
    wr(ccp_pkg::ADDR_CMPB, 32'd30);
    wr(ccp_pkg::ADDR_CTRL, {16'h0, r.ctrl});
    // The unit runs one cycle after the write; an earlier edge would be lost
    wait_cyc(2);
    for (int k = 0; k < 32; k++) begin
      captureIn <= ~captureIn;
      wait_cyc(5);
    end
    wait_cyc(4);
    wr(ccp_pkg::ADDR_CTRL, 32'h0);
    wait_cyc(4);
    check(32'(nCapt), 32'(r.ec));
    if (r.em >= 0) check(32'(nCmp), 32'(r.em));
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    foreach (rows[i]) run_row(rows[i]);
    $display("Test mode table done");

    // Reset values, write mask, back-to-back access, unmapped and read-only places
    do_reset;
    check({running, compareOut, captureEvent}, 32'h0);
    check(captureValue, 32'h0);
    rd(ccp_pkg::ADDR_CTRL, q0);
    check(q0, {16'h0, ccp_pkg::CTRL_RESET});
    rd(ccp_pkg::ADDR_PERIOD, q0);
    check(q0, ccp_pkg::PERIOD_RESET);
    wr(ccp_pkg::ADDR_CTRL, 32'hffffffff);
    rd(ccp_pkg::ADDR_CTRL, q0);
    check(q0, {16'h0, ccp_pkg::CTRL_WMASK});
    wr(ccp_pkg::ADDR_CAPT, 32'hffffffff);
    rd(ccp_pkg::ADDR_CAPT, q0);
    check(q0, 32'h0);
    rd(5'h1c, q0);
    check(q0, 32'h0);
    $display("Test registers done");

    // Sleep halts the unit unless run-in-sleep is set
    do_reset;
    wr(ccp_pkg::ADDR_CTRL, 32'h8000);
    wait_cyc(3);
    check(running, 1'b1);
    sleepActive <= 1'b1;
    wait_cyc(3);
    check(running, 1'b0);
    rd(ccp_pkg::ADDR_STATUS, q0);
    check(q0, 32'h10);
    wr(ccp_pkg::ADDR_CTRL, 32'h9000);
    wait_cyc(3);
    check(running, 1'b1);
    wr(ccp_pkg::ADDR_CTRL, 32'h1000);
    wait_cyc(3);
    check(running, 1'b0);
    $display("Test sleep done");

    // Reads 128 cycles apart see exactly 128 divided by the prescale
    for (int d = 0; d < 4; d++) begin
      do_reset;
      wr(ccp_pkg::ADDR_CTRL, 32'h8000 | (32'(d) << 6));
      wait_cyc(10);
      rd(ccp_pkg::ADDR_TIMER, q0);
      wait_cyc(126);
      rd(ccp_pkg::ADDR_TIMER, q1);
      check((q1 - q0) & 32'hffff, 32'd128 >> (2 * d));
    end
    $display("Test prescaler done");

    // External source one, with and without resynchronisation
    for (int s = 0; s < 2; s++) begin
      do_reset;
      wr(ccp_pkg::ADDR_CTRL, 32'h8100 | (32'(s) << 11));
      wait_cyc(2);
      for (int k = 0; k < 16; k++) begin
        extClk[1] <= ~extClk[1];
        wait_cyc(2);
      end
      wait_cyc(6);
      rd(ccp_pkg::ADDR_TIMER, q0);
      check(q0, 32'd8);
    end
    $display("Test external source done");

    // Mode change in flight: set-high then drive-low on the next match
    do_reset;
    wr(ccp_pkg::ADDR_PERIOD, 32'd49);
    wr(ccp_pkg::ADDR_CMPA, 32'd3);
    wr(ccp_pkg::ADDR_CTRL, 32'h8001);
    wait_cyc(60);
    check(compareOut, 1'b1);
    wr(ccp_pkg::ADDR_CTRL, 32'h8002);
    wait_cyc(60);
    check(compareOut, 1'b0);
    $display("Test set and clear done");

    // Captured value, sticky flag, clear by reading, capture beside the clearing read
    do_reset;
    wr(ccp_pkg::ADDR_CTRL, 32'h8011);
    wait_cyc(10);
    captureIn <= 1'b1;
    wait_cyc(3);
    check(captureValue, 32'h8);
    rd(ccp_pkg::ADDR_STATUS, q0);
    check(q0, 32'h9);
    rd(ccp_pkg::ADDR_CAPT, q0);
    check(q0, 32'h8);
    rd(ccp_pkg::ADDR_STATUS, q0);
    check(q0, 32'h8);
    captureIn <= 1'b0;
    wait_cyc(2);
    captureIn <= 1'b1;
    rd(ccp_pkg::ADDR_CAPT, q0);
    rd(ccp_pkg::ADDR_STATUS, q1);
    check(q0, 32'h8);
    check(q1, 32'h9);
    @(posedge sys_clk);
    check(rdata, 32'h0);
    $display("Test capture readback done");

    // Period above 16 bits: the narrow timer wraps at its low half, the wide one does not
    for (int w = 0; w < 2; w++) begin
      do_reset;
      wr(ccp_pkg::ADDR_PERIOD, 32'h0001_0031);
      wr(ccp_pkg::ADDR_CTRL, 32'h8000 | (32'(w) << 5));
      wait_cyc(60);
      rd(ccp_pkg::ADDR_TIMER, q0);
      check(q0, (w == 0) ? 32'h8 : 32'h3a);
    end
    $display("Test timer width done");
    report_and_stop;
  end
endmodule
`default_nettype wire
